// ===== src/ccc_count_channel.sv
// One configurable 32-bit count channel with AXI4-Lite registers
`timescale 1ns/1ps
`default_nettype none
module ccc_count_channel #(
	parameter int CHANNEL = 3
) (
	// Clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// AXI4-Lite write address
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [ccc_pkg::AXI_ADDR_W-1:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	// AXI4-Lite write data
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	input wire logic [ccc_pkg::AXI_DATA_W-1:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	// AXI4-Lite write response
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	output logic [1:0] s_axi_bresp,
	// AXI4-Lite read address
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	input wire logic [ccc_pkg::AXI_ADDR_W-1:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	// AXI4-Lite read data
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic [ccc_pkg::AXI_DATA_W-1:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	// Sensor inputs
	input wire logic trackA,
	input wire logic trackB,
	input wire logic gateIn,
	// Comparator output
	output logic cmpOut
);
	import ccc_pkg::*;

	localparam bit HAS_HARDWARE_COUNT_GATE = (CHANNEL == HARDWARE_COUNT_GATE_CHANNEL);

	function automatic logic isMapped(input logic [AXI_ADDR_W-1:0] a);
		isMapped = (a < REG_SPAN);
	endfunction

	function automatic logic [31:0] mergeStrb(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
		begin
			if (strb[i])
				r[i*8 +: 8] = nw[i*8 +: 8];
		end
		mergeStrb = r;
	endfunction

	// ------------------------------------------------------------
	// AXI4-Lite slave
	// ------------------------------------------------------------
	logic awHeld_q, wHeld_q, bvalid_q, rvalid_q;
	logic [AXI_ADDR_W-1:0] awAddr_q;
	logic [31:0] wData_q, rData_q;
	logic [3:0] wStrb_q;
	logic [1:0] bResp_q, rResp_q;
	logic doWrite;
	logic [31:0] readMux;

	assign s_axi_awready = !awHeld_q && !bvalid_q;
	assign s_axi_wready = !wHeld_q && !bvalid_q;
	assign s_axi_arready = !rvalid_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bResp_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata = rData_q;
	assign s_axi_rresp = rResp_q;
	assign doWrite = awHeld_q && wHeld_q && !bvalid_q;

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			awHeld_q <= 1'b0;
			wHeld_q <= 1'b0;
			awAddr_q <= '0;
			wData_q <= '0;
			wStrb_q <= '0;
		end
		else if (doWrite)
		begin
			awHeld_q <= 1'b0;
			wHeld_q <= 1'b0;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				awHeld_q <= 1'b1;
				awAddr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				wHeld_q <= 1'b1;
				wData_q <= s_axi_wdata;
				wStrb_q <= s_axi_wstrb;
			end
		end
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			bvalid_q <= 1'b0;
			bResp_q <= RESP_OKAY;
		end
		else if (doWrite)
		begin
			bvalid_q <= 1'b1;
			bResp_q <= isMapped(awAddr_q) ? RESP_OKAY : RESP_SLVERR;
		end
		else if (s_axi_bready)
			bvalid_q <= 1'b0;
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			rvalid_q <= 1'b0;
			rData_q <= '0;
			rResp_q <= RESP_OKAY;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			rvalid_q <= 1'b1;
			rData_q <= isMapped(s_axi_araddr) ? readMux : 32'h0000_0000;
			rResp_q <= isMapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
		end
		else if (s_axi_rready)
			rvalid_q <= 1'b0;
	end

	// ------------------------------------------------------------
	// Configuration registers
	// ------------------------------------------------------------
	logic [CTRL_W-1:0] ctrl_q;
	logic signed [CNT_W-1:0] load_q, start_q, end_q, cmp_q, count_q;
	logic [HYST_W-1:0] hyst_q;
	logic [31:0] wrVal;
	ccc_dir_type mainDir;
	ccc_eval_type evalMode;
	logic swGate, gateStop, hwGateEn, dirInvert, contMode;

	assign mainDir = ccc_dir_type'(ctrl_q[CTRL_DIR_LO +: 2]);
	assign evalMode = ccc_eval_type'(ctrl_q[CTRL_EVAL_LO +: 2]);
	assign swGate = ctrl_q[CTRL_SWGATE];
	assign gateStop = ctrl_q[CTRL_GATESTOP];
	assign hwGateEn = ctrl_q[CTRL_HWGATE];
	assign dirInvert = ctrl_q[CTRL_INVERT];
	assign contMode = ctrl_q[CTRL_CONT];

	always_comb
	begin
		wrVal = 32'h0000_0000;
		case (awAddr_q)
			OFS_CTRL: wrVal = mergeStrb({{(32-CTRL_W){1'b0}}, ctrl_q}, wData_q, wStrb_q);
			OFS_LOAD: wrVal = mergeStrb(load_q, wData_q, wStrb_q);
			OFS_START: wrVal = mergeStrb(start_q, wData_q, wStrb_q);
			OFS_END: wrVal = mergeStrb(end_q, wData_q, wStrb_q);
			OFS_CMP: wrVal = mergeStrb(cmp_q, wData_q, wStrb_q);
			OFS_HYST: wrVal = mergeStrb({24'h00_0000, hyst_q}, wData_q, wStrb_q);
			default: wrVal = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			ctrl_q <= CTRL_RESET;
			load_q <= LOAD_RESET;
			start_q <= LIMIT_RESET;
			end_q <= LIMIT_RESET;
			cmp_q <= CMP_RESET;
			hyst_q <= HYST_RESET;
		end
		else if (doWrite)
		begin
			case (awAddr_q)
				OFS_CTRL: ctrl_q <= wrVal[CTRL_W-1:0];
				OFS_LOAD: load_q <= wrVal;
				// Limits clamp into their legal range (see RULE7)
				OFS_START: start_q <= ($signed(wrVal) < LIMIT_MIN) ? LIMIT_MIN : wrVal;
				OFS_END: end_q <= ($signed(wrVal) < LIMIT_MIN) ? LIMIT_MIN : wrVal;
				OFS_CMP: cmp_q <= wrVal;
				OFS_HYST: hyst_q <= wrVal[HYST_W-1:0];
				default: ;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Input edges and step decoding
	// ------------------------------------------------------------
	logic a_q, b_q, g_q;
	logic aRise, aFall, bRise, bFall, aEdge, bEdge;
	logic step, upRaw, countUp;

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			a_q <= 1'b0;
			b_q <= 1'b0;
			g_q <= 1'b0;
		end
		else
		begin
			a_q <= trackA;
			b_q <= trackB;
			g_q <= gateIn;
		end
	end

	assign aRise = trackA && !a_q;
	assign aFall = !trackA && a_q;
	assign bRise = trackB && !b_q;
	assign bFall = !trackB && b_q;
	assign aEdge = aRise || aFall;
	assign bEdge = bRise || bFall;

	always_comb
	begin
		step = 1'b0;
		upRaw = 1'b0;
		case (evalMode)
			EVAL_PULSE_DIR:
			begin
				step = aRise; // see RULE13
				upRaw = trackB;
			end
			EVAL_SINGLE:
			begin
				step = aRise; // see RULE14
				upRaw = !trackB;
			end
			EVAL_DOUBLE:
			begin
				step = aEdge; // see RULE14
				upRaw = trackA ^ trackB;
			end
			EVAL_QUAD:
			begin
				step = aEdge ^ bEdge; // see RULE14
				upRaw = aEdge ? (trackA ^ trackB) : !(trackA ^ trackB);
			end
			default:
			begin
				step = 1'b0;
				upRaw = 1'b0;
			end
		endcase
	end

	assign countUp = upRaw ^ dirInvert; // see RULE17

	// ------------------------------------------------------------
	// Gate
	// ------------------------------------------------------------
	logic hwGate_q, gateOpen_q, gateOpen, gateOpenRise, hwUsed;

	assign hwUsed = HAS_HARDWARE_COUNT_GATE && hwGateEn;
	// see RULE15, see RULE16, see RULE19
	assign gateOpen = swGate && (!hwUsed || hwGate_q);
	assign gateOpenRise = gateOpen && !gateOpen_q;

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			hwGate_q <= 1'b0;
		else if (!hwUsed)
			hwGate_q <= 1'b0;
		else if (gateIn && !g_q)
			hwGate_q <= 1'b1; // see RULE18
		else if (!gateIn && g_q)
			hwGate_q <= 1'b0;
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			gateOpen_q <= 1'b0;
		else
			gateOpen_q <= gateOpen;
	end

	// ------------------------------------------------------------
	// Counter
	// ------------------------------------------------------------
	logic signed [CNT_W-1:0] endLast;
	assign endLast = end_q - ONE;

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			count_q <= COUNT_RESET;
		else if (gateOpenRise && !gateStop)
			count_q <= load_q; // see RULE5
		else if (step && gateOpen) // see RULE6, see RULE20
		begin
			case (mainDir)
				DIR_UP:
					if (countUp)
						count_q <= (count_q >= endLast) ? load_q : count_q + ONE; // see RULE2
					else
						count_q <= count_q - ONE;
				DIR_DOWN:
					if (!countUp)
						// see RULE3, see RULE4
						count_q <= (!contMode && count_q <= DOWN_FLOOR) ? start_q : count_q - ONE;
					else
						count_q <= count_q + ONE;
				default:
					count_q <= countUp ? count_q + ONE : count_q - ONE; // see RULE1
			endcase
		end
	end

	// ------------------------------------------------------------
	// Comparator with hysteresis
	// ------------------------------------------------------------
	logic signed [CNT_W:0] lowThr;
	logic cmp_hit;
	assign lowThr = {cmp_q[CNT_W-1], cmp_q} - $signed({1'b0, {(CNT_W-HYST_W){1'b0}}, hyst_q});
	assign cmp_hit = count_q >= cmp_q;

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			cmpOut <= 1'b0;
		else if (cmp_hit)
			cmpOut <= 1'b1; // see RULE8
		else if (hyst_q <= HYST_OFF_MAX)
			cmpOut <= 1'b0;
		else if ($signed({count_q[CNT_W-1], count_q}) < lowThr)
			cmpOut <= 1'b0; // see RULE11
	end

	// ------------------------------------------------------------
	// Read mux
	// ------------------------------------------------------------
	always_comb
	begin
		readMux = 32'h0000_0000;
		case (s_axi_araddr)
			OFS_CTRL: readMux = {{(32-CTRL_W){1'b0}}, ctrl_q};
			OFS_LOAD: readMux = load_q;
			OFS_START: readMux = start_q;
			OFS_END: readMux = end_q;
			OFS_CMP: readMux = cmp_q;
			OFS_HYST: readMux = {24'h00_0000, hyst_q};
			OFS_COUNT: readMux = count_q;
			OFS_STATUS:
			begin
				readMux[STS_CMP] = cmpOut;
				readMux[STS_GATE] = gateOpen;
				readMux[STS_HWGATE] = hwGate_q;
				readMux[STS_UP] = countUp;
			end
			default: readMux = 32'h0000_0000;
		endcase
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	logic stepGo;
	assign stepGo = step && gateOpen && !(gateOpenRise && !gateStop);

	property p_freeCount;
		@(posedge clk) disable iff (!arst_n)
		stepGo && mainDir == DIR_NONE && countUp |=> count_q == $past(count_q) + ONE;
	endproperty
	a_freeCount: assert property (p_freeCount) else $error("free count missed step"); // see RULE1

	property p_upWrap;
		@(posedge clk) disable iff (!arst_n)
		stepGo && mainDir == DIR_UP && countUp && count_q >= endLast |=> count_q == $past(load_q);
	endproperty
	a_upWrap: assert property (p_upWrap) else $error("up wrap not to load"); // see RULE2

	property p_downWrap;
		@(posedge clk) disable iff (!arst_n)
		stepGo && mainDir == DIR_DOWN && !countUp && !contMode && count_q <= DOWN_FLOOR
		|=> count_q == $past(start_q);
	endproperty
	a_downWrap: assert property (p_downWrap) else $error("down wrap not to start"); // see RULE3

	property p_contDown;
		@(posedge clk) disable iff (!arst_n)
		stepGo && mainDir == DIR_DOWN && !countUp && contMode |=> count_q == $past(count_q) - ONE;
	endproperty
	a_contDown: assert property (p_contDown) else $error("continuous down restricted"); // see RULE4

	property p_cancelReload;
		@(posedge clk) disable iff (!arst_n)
		gateOpenRise && !gateStop |=> count_q == $past(load_q);
	endproperty
	a_cancelReload: assert property (p_cancelReload) else $error("no reload on open"); // see RULE5

	property p_stopHold;
		@(posedge clk) disable iff (!arst_n)
		!gateOpen ##1 !gateOpen[*2] |-> $stable(count_q);
	endproperty
	a_stopHold: assert property (p_stopHold) else $error("count moved while closed"); // see RULE6

	property p_cmpHigh;
		@(posedge clk) disable iff (!arst_n)
		cmp_hit |=> cmpOut;
	endproperty
	a_cmpHigh: assert property (p_cmpHigh) else $error("compare not set"); // see RULE8

	property p_noHyst;
		@(posedge clk) disable iff (!arst_n)
		!cmp_hit && hyst_q <= HYST_OFF_MAX |=> !cmpOut;
	endproperty
	a_noHyst: assert property (p_noHyst) else $error("compare held without hysteresis"); // see RULE11

	property p_hwGateClosed;
		@(posedge clk) disable iff (!arst_n)
		hwUsed && !hwGate_q |=> count_q == $past(count_q);
	endproperty
	a_hwGateClosed: assert property (p_hwGateClosed) else $error("gate open, hw closed"); // see RULE15

	property p_swOnly;
		@(posedge clk) disable iff (!arst_n)
		!hwUsed && swGate && !gateOpen_q && !gateStop |=> count_q == $past(load_q);
	endproperty
	a_swOnly: assert property (p_swOnly) else $error("gate differs from software_count_gate"); // see RULE16

	property p_hwRise;
		@(posedge clk) disable iff (!arst_n)
		hwUsed && gateIn && !g_q ##1 hwUsed |-> hwGate_q;
	endproperty
	a_hwRise: assert property (p_hwRise) else $error("hardware_count_gate not opened"); // see RULE18

	c_upWrap: cover property (@(posedge clk) disable iff (!arst_n)
		stepGo && mainDir == DIR_UP && countUp && count_q >= endLast);
	c_downWrap: cover property (@(posedge clk) disable iff (!arst_n)
		stepGo && mainDir == DIR_DOWN && !countUp && count_q <= DOWN_FLOOR);
	c_hwOpen: cover property (@(posedge clk) disable iff (!arst_n) hwUsed && gateOpenRise);
	c_hystHold: cover property (@(posedge clk) disable iff (!arst_n)
		!cmp_hit && cmpOut && hyst_q > HYST_OFF_MAX);
endmodule
`default_nettype wire

// ===== src/ccc_pkg.sv
// Constants, register map and field layout of the count channel
//
// Behaviour
// RULE1 - No main direction: count freely both ways
// RULE2 - Up: count to end minus one, reload
// RULE3 - Down: count to one, then jump start
// RULE4 - Continuous mode lifts the downward restriction
// RULE5 - Cancel gate: every opening reloads load value
// RULE6 - Stop gate: closed gate holds actual count
// RULE7 - Start/end limits 2 to 2^31-1, default max
// RULE8 - Compare count against value, default zero
// RULE9 - Software keeps forward comparison below end
// RULE10 - Software keeps backward comparison 1 to max
// RULE11 - Hysteresis damps output toggling; 0,1 disable
// RULE12 - Software sets hysteresis 0..255, default 0
// RULE13 - Pulse/direction: pulses on A, direction B
// RULE14 - Encoder evaluation single, double or quadruple
// RULE15 - Channel 3 hardware gate ANDs with software
// RULE16 - Hardware gate disabled: software gate only
// RULE17 - Optional inversion of the direction input
// RULE18 - Hardware gate opens on input rising edge
// RULE19 - Channels 0-2 gated by software only
// RULE20 - Counter is signed 32 bits, per edge
package ccc_pkg;
	localparam int AXI_ADDR_W = 6;
	localparam int AXI_DATA_W = 32;
	localparam int CNT_W = 32;
	localparam int HYST_W = 8;
	localparam int HARDWARE_COUNT_GATE_CHANNEL = 3;

	// Register byte offsets
	localparam logic [AXI_ADDR_W-1:0] OFS_CTRL = 6'h00;
	localparam logic [AXI_ADDR_W-1:0] OFS_LOAD = 6'h04;
	localparam logic [AXI_ADDR_W-1:0] OFS_START = 6'h08;
	localparam logic [AXI_ADDR_W-1:0] OFS_END = 6'h0C;
	localparam logic [AXI_ADDR_W-1:0] OFS_CMP = 6'h10;
	localparam logic [AXI_ADDR_W-1:0] OFS_HYST = 6'h14;
	localparam logic [AXI_ADDR_W-1:0] OFS_COUNT = 6'h18;
	localparam logic [AXI_ADDR_W-1:0] OFS_STATUS = 6'h1C;
	localparam logic [AXI_ADDR_W-1:0] REG_SPAN = 6'h20;

	// Control fields
	localparam int CTRL_SWGATE = 0;
	localparam int CTRL_DIR_LO = 1;
	localparam int CTRL_GATESTOP = 3;
	localparam int CTRL_EVAL_LO = 4;
	localparam int CTRL_HWGATE = 6;
	localparam int CTRL_INVERT = 7;
	localparam int CTRL_CONT = 8;
	localparam int CTRL_W = 9;

	// Status fields
	localparam int STS_CMP = 0;
	localparam int STS_GATE = 1;
	localparam int STS_HWGATE = 2;
	localparam int STS_UP = 3;

	typedef enum logic [1:0] {
		DIR_NONE = 2'h0,
		DIR_UP = 2'h1,
		DIR_DOWN = 2'h2
	} ccc_dir_type;

	typedef enum logic [1:0] {
		EVAL_PULSE_DIR = 2'h0,
		EVAL_SINGLE = 2'h1,
		EVAL_DOUBLE = 2'h2,
		EVAL_QUAD = 2'h3
	} ccc_eval_type;

	localparam logic [CTRL_W-1:0] CTRL_RESET = 9'h000;
	localparam logic signed [CNT_W-1:0] LOAD_RESET = 32'sh0000_0000;
	localparam logic signed [CNT_W-1:0] LIMIT_RESET = 32'sh7FFF_FFFF;
	localparam logic signed [CNT_W-1:0] LIMIT_MIN = 32'sh0000_0002;
	localparam logic signed [CNT_W-1:0] CMP_RESET = 32'sh0000_0000;
	localparam logic [HYST_W-1:0] HYST_RESET = 8'h00;
	localparam logic [HYST_W-1:0] HYST_OFF_MAX = 8'h01;
	localparam logic signed [CNT_W-1:0] COUNT_RESET = 32'sh0000_0000;
	localparam logic signed [CNT_W-1:0] DOWN_FLOOR = 32'sh0000_0001;
	localparam logic signed [CNT_W-1:0] ONE = 32'sh0000_0001;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ===== sim/ccc_encoder_model.sv
// Encoder and pulse/direction source that drives the count tracks
`timescale 1ns/1ps
`default_nettype none
module ccc_encoder_model (
	// Clock
	input wire logic clk,
	// Step request from the bench
	input wire logic stepReq,
	input wire logic stepUp,
	input wire logic quadMode,
	input wire logic [1:0] holdCycles,
	output logic stepDone,
	// Sensor tracks
	output logic trackA,
	output logic trackB
);
	initial
	begin
		trackA = 1'b0;
		trackB = 1'b0;
		stepDone = 1'b0;
		forever
		begin
			@(posedge clk);
			if (stepDone && !stepReq)
				stepDone <= 1'b0;
			else if (stepReq && !stepDone)
			begin
				// Quarter step, A leads B going up
				if (quadMode)
					{trackA, trackB} <= stepUp ? {~trackB, trackA} : {trackB, ~trackA};
				else
				begin
					trackB <= stepUp;
					repeat (holdCycles) @(posedge clk);
					trackA <= 1'b1;
					repeat (holdCycles) @(posedge clk);
					trackA <= 1'b0;
				end
				repeat (holdCycles) @(posedge clk);
				stepDone <= 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

// ===== sim/tb.sv
// Self-checking bench for the count channel
`timescale 1ns/1ps
`default_nettype none
module tb;
	import ccc_pkg::*;
	logic clk, arst_n, trackA, trackB, gateIn, cmpOut, stepReq, stepUp, quadMode, stepDone;
	logic [1:0] holdCycles, s_axi_bresp, s_axi_rresp;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [AXI_ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
	logic [AXI_DATA_W-1:0] s_axi_wdata, s_axi_rdata;
	logic [33:0] expR[$], expB[$];
	logic signed [31:0] ex, loadv, startv, endv, cmpv, hy;
	logic [1:0] mdir;
	logic cont, cmpq;
	int n_mismatch, comparisons, seed;

	ccc_count_channel i_ccc_count_channel (
		.clk(clk), .arst_n(arst_n),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(3'h0),
		.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
		.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arprot(3'h0),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.trackA(trackA), .trackB(trackB), .gateIn(gateIn), .cmpOut(cmpOut)
	);
	ccc_encoder_model i_ccc_encoder_model (
		.clk(clk), .stepReq(stepReq), .stepUp(stepUp), .quadMode(quadMode),
		.holdCycles(holdCycles), .stepDone(stepDone), .trackA(trackA), .trackB(trackB)
	);

	always #2 clk = ~clk;

	// -------------------------------------------------
	// Bus and step tasks
	// -------------------------------------------------
	task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic complete_run;
		$display("comparisons=%0d mismatches=%0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// Wait for arready, bvalid, rvalid or stepDone, then for the taking edge
	task automatic waitFor(input int w);
		int k;
		for (k = 0; k < 300; k++)
		begin
			@(negedge clk);
			if ((w == 0 ? s_axi_arready : w == 1 ? s_axi_bvalid : w == 2 ? s_axi_rvalid : stepDone) === 1'b1)
				break;
		end
		if (k == 300)
		begin
			n_mismatch++;
			$display("ERROR t=%0t wait %0d timed out", $time, w);
			complete_run;
		end
		@(posedge clk);
	endtask

	task automatic wr(input logic [5:0] a, input logic [31:0] d);
		logic ta, tw, pa, pw;
		int k;
		expB.push_back({(a >= REG_SPAN) ? RESP_SLVERR : RESP_OKAY, 32'h0});
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		pa = 1'b1;
		pw = 1'b1;
		for (k = 0; k < 300 && (pa || pw); k++)
		begin
			@(negedge clk);
			ta = pa && s_axi_awready;
			tw = pw && s_axi_wready;
			@(posedge clk);
			if (ta)
				s_axi_awvalid <= 1'b0;
			if (tw)
				s_axi_wvalid <= 1'b0;
			pa = pa && !ta;
			pw = pw && !tw;
		end
		if (pa || pw)
		begin
			n_mismatch++;
			$display("ERROR t=%0t write address or data not taken", $time);
			complete_run;
		end
		s_axi_bready <= 1'b1;
		waitFor(1);
		s_axi_bready <= 1'b0;
	endtask

	task automatic rd(input logic [5:0] a, input logic [31:0] d);
		expR.push_back({(a >= REG_SPAN) ? RESP_SLVERR : RESP_OKAY, d});
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		waitFor(0);
		s_axi_arvalid <= 1'b0;
		s_axi_rready <= 1'b1;
		waitFor(2);
		s_axi_rready <= 1'b0;
	endtask

	task automatic step(input logic up);
		stepUp <= up;
		holdCycles <= 2'h1 + 2'($unsigned($random(seed)) % 3);
		stepReq <= 1'b1;
		waitFor(3);
		stepReq <= 1'b0;
		@(posedge clk);
	endtask

	function automatic logic signed [31:0] nxt(input logic up);
		if (up)
			return (mdir == DIR_UP && ex >= endv - 32'sh1) ? loadv : ex + 32'sh1;
		return (mdir == DIR_DOWN && !cont && ex <= 32'sh1) ? startv : ex - 32'sh1;
	endfunction

	task automatic run(input logic up, input int n);
		repeat (n)
		begin
			step(up);
			ex = nxt(up);
			if (ex >= cmpv)
				cmpq = 1'b1;
			else if (ex < cmpv - ((hy > 32'sh1) ? hy : 32'sh0))
				cmpq = 1'b0;
			rd(OFS_COUNT, ex);
		end
	endtask

	// Close then open the gate in cancel mode
	task automatic opn(input logic [31:0] c);
		mdir = c[2:1];
		cont = c[8];
		wr(OFS_CTRL, c);
		wr(OFS_CTRL, c | 32'h1);
		ex = loadv;
		cmpq = (ex >= cmpv);
	endtask

	task automatic cmpRun(input logic [31:0] c);
		opn(c);
		for (int i = 0; i < 6; i++)
		begin
			run(i < 3, 1);
			rd(OFS_STATUS, {28'h0, i < 3, 2'h1, cmpq});
			chk({33'h0, cmpOut}, {33'h0, cmpq});
		end
	endtask

	// -------------------------------------------------
	// Result monitor
	// -------------------------------------------------
	always @(negedge clk)
	begin
		if (s_axi_rvalid && s_axi_rready)
			chk({s_axi_rresp, s_axi_rdata}, expR.pop_front());
		if (s_axi_bvalid && s_axi_bready)
			chk({s_axi_bresp, 32'h0}, expB.pop_front());
	end

	// -------------------------------------------------
	// Main sequence
	// -------------------------------------------------
	initial
	begin
		clk = 1'b0;
		arst_n = 1'b0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 44'h0;
		{gateIn, stepReq, stepUp, quadMode, holdCycles} = 6'h01;
		{n_mismatch, comparisons, seed} = {32'h0, 32'h0, 32'h5F};
		{ex, loadv, cmpv, hy, mdir, cont, cmpq} = 132'h0;
		startv = LIMIT_RESET;
		endv = LIMIT_RESET;
		repeat (20) @(posedge clk);
		arst_n <= 1'b1;
		@(posedge clk);
		rd(OFS_CTRL, 32'h0);
		rd(OFS_LOAD, 32'h0);
		rd(OFS_START, LIMIT_RESET);
		rd(OFS_END, LIMIT_RESET);
		rd(OFS_CMP, CMP_RESET);
		rd(OFS_HYST, 32'h0);
		rd(6'h24, 32'h0);
		wr(6'h28, 32'h5);
		wr(OFS_COUNT, 32'h5);
		step(1'b1);
		rd(OFS_COUNT, 32'h0);
		$display("test defaults done");
		loadv = $random(seed);
		wr(OFS_LOAD, loadv);
		opn(32'h0);
		rd(OFS_COUNT, ex);
		run(1'b1, 1 + $unsigned($random(seed)) % 4);
		run(1'b0, 1 + $unsigned($random(seed)) % 6);
		loadv = LIMIT_RESET;
		wr(OFS_LOAD, loadv);
		opn(32'h0);
		run(1'b1, 2);
		opn(32'h80);
		step(1'b1);
		ex = ex - 32'sh1;
		rd(OFS_COUNT, ex);
		$display("test free counting done");
		loadv = 32'shA;
		wr(OFS_LOAD, loadv);
		opn(32'h0);
		run(1'b1, 2);
		wr(OFS_CTRL, 32'h0);
		step(1'b1);
		wr(OFS_CTRL, 32'h1);
		ex = loadv;
		rd(OFS_COUNT, ex);
		run(1'b1, 1);
		wr(OFS_CTRL, 32'h8);
		step(1'b1);
		wr(OFS_CTRL, 32'h9);
		rd(OFS_COUNT, ex);
		run(1'b1, 1);
		$display("test gate modes done");
		wr(OFS_END, 32'h1);
		rd(OFS_END, LIMIT_MIN);
		endv = 32'sh5;
		loadv = 32'sh2;
		wr(OFS_END, endv);
		wr(OFS_LOAD, loadv);
		opn(32'h2);
		run(1'b1, 4);
		run(1'b0, 3);
		startv = 32'sh4;
		loadv = 32'sh3;
		wr(OFS_START, startv);
		wr(OFS_LOAD, loadv);
		opn(32'h4);
		run(1'b0, 4);
		opn(32'h104);
		run(1'b0, 4);
		$display("test limits done");
		loadv = 32'sh0;
		wr(OFS_LOAD, loadv);
		quadMode <= 1'b1;
		for (int ev = 1; ev < 4; ev++)
		begin
			opn(32'(ev) << 4);
			repeat (8) step(1'b1);
			ex = 32'sh2 << (ev - 1);
			rd(OFS_COUNT, ex);
		end
		quadMode <= 1'b0;
		$display("test evaluation done");
		cmpv = 32'sh3;
		hy = 32'sh2;
		wr(OFS_CMP, cmpv);
		wr(OFS_HYST, hy);
		cmpRun(32'h2);
		hy = 32'sh1;
		wr(OFS_HYST, hy);
		cmpRun(32'h4);
		$display("test comparator done");
		loadv = 32'sh7;
		wr(OFS_LOAD, loadv);
		wr(OFS_CTRL, 32'h41);
		step(1'b1);
		rd(OFS_COUNT, ex);
		gateIn <= 1'b1;
		repeat (2) @(posedge clk);
		ex = loadv;
		rd(OFS_COUNT, ex);
		rd(OFS_STATUS, 32'hF);
		run(1'b1, 1);
		gateIn <= 1'b0;
		repeat (2) @(posedge clk);
		step(1'b1);
		rd(OFS_COUNT, ex);
		rd(OFS_STATUS, 32'h9);
		opn(32'h0);
		run(1'b1, 1);
		$display("test hardware gate done");
		complete_run;
	end
endmodule
`default_nettype wire
